//--- verilog/csb_defines.svh
`ifndef CSB_DEFINES_SVH
`define CSB_DEFINES_SVH
// ****************************************************************
// Register map of the APB slave, byte addresses.
// ****************************************************************
`define CSB_OFS_CTRL   12'h000
`define CSB_OFS_FLAGS  12'h004
`define CSB_OFS_PC     12'h008
`define CSB_OFS_COUNT  12'h00C
// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CSB_CTRL_EN_BIT   0
`define CSB_CTRL_RST      1'h1
`define CSB_FLAGS_RST     8'h00
`define CSB_PC_RST        16'h0000
`define CSB_FLAG_C        0
`define CSB_FLAG_Z        1
`define CSB_FLAG_N        2
`define CSB_FLAG_V        3
`define CSB_FLAG_S        4
`define CSB_FLAG_H        5
// ****************************************************************
// Instruction encodings as mask and match pairs.
// ****************************************************************
`define CSB_M_CP    16'hFC00
`define CSB_V_CP    16'h1400
`define CSB_M_CPC   16'hFC00
`define CSB_V_CPC   16'h0400
`define CSB_M_CPI   16'hF000
`define CSB_V_CPI   16'h3000
`define CSB_M_SBR   16'hFE08
`define CSB_V_SKIP_IF_REG_BIT_CLEAR  16'hFC00
`define CSB_V_SKIP_IF_REG_BIT_SET  16'hFE00
`define CSB_M_SBI   16'hFF00
`define CSB_V_SKIP_IF_IO_BIT_CLEAR  16'h9900
`define CSB_V_SKIP_IF_IO_BIT_SET  16'h9B00
`define CSB_M_BRB   16'hFC00
`define CSB_V_BRANCH_IF_FLAG_SET  16'hF000
`define CSB_V_BRANCH_IF_FLAG_CLEAR  16'hF400
`endif

//--- verilog/csb_pkg.sv
`default_nettype none
`include "csb_defines.svh"
package csb_pkg;
  // Operation classes recognised by the execution block.
  typedef enum logic [3:0] {
    op_none, op_cmp, op_cmpc, op_cmpi, op_skrc, op_skrs,
    op_skic, op_skis, op_brs, op_brc
  } csb_op_t;

  // Classifies one instruction word; anything else is a plain step.
  function automatic csb_op_t csb_decode(input logic [15:0] w);
    csb_op_t op;
    op = op_none;
    if ((w & `CSB_M_CP) == `CSB_V_CP) op = op_cmp;
    else if ((w & `CSB_M_CPC) == `CSB_V_CPC) op = op_cmpc;
    else if ((w & `CSB_M_CPI) == `CSB_V_CPI) op = op_cmpi;
    else if ((w & `CSB_M_SBR) == `CSB_V_SKIP_IF_REG_BIT_CLEAR) op = op_skrc;
    else if ((w & `CSB_M_SBR) == `CSB_V_SKIP_IF_REG_BIT_SET) op = op_skrs;
    else if ((w & `CSB_M_SBI) == `CSB_V_SKIP_IF_IO_BIT_CLEAR) op = op_skic;
    else if ((w & `CSB_M_SBI) == `CSB_V_SKIP_IF_IO_BIT_SET) op = op_skis;
    else if ((w & `CSB_M_BRB) == `CSB_V_BRANCH_IF_FLAG_SET) op = op_brs;
    else if ((w & `CSB_M_BRB) == `CSB_V_BRANCH_IF_FLAG_CLEAR) op = op_brc;
    return op;
  endfunction
endpackage
`default_nettype wire

//--- verilog/csb_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
// Operands and flag results of the compare subtractor.
interface csb_alu_if;
  logic [7:0] a;        // Minuend.
  logic [7:0] b;        // Subtrahend.
  logic       cin;      // Current carry flag.
  logic       zin;      // Current zero flag.
  logic       use_cin;  // High for the carry-chained compare.
  logic       c;        // Borrow out.
  logic       z;        // Zero result.
  logic       n;        // Sign of result.
  logic       v;        // Two's complement overflow.
  logic       h;        // Borrow from bit 3.
  modport alu  (input a, b, cin, zin, use_cin, output c, z, n, v, h);
  modport core (output a, b, cin, zin, use_cin, input c, z, n, v, h);
endinterface
`default_nettype wire

//--- verilog/csb_alu.sv
`timescale 1ns/1ps
`default_nettype none
// Subtractor that only produces flags; the difference is never stored.
module csb_alu
(
  csb_alu_if.alu bus  // Operand and flag bundle.
);
  logic [8:0] diff;  // Difference with borrow in bit 8.
  logic [7:0] res;   // Low byte of the difference.

  // ****************************************************************
  // Flag arithmetic.
  // ****************************************************************
  // The carry is subtracted only for the chained form.
  always_comb
  begin
    diff = {1'b0, bus.a} - {1'b0, bus.b} - {8'h00, bus.cin & bus.use_cin};
    res  = diff[7:0];
  end

  assign bus.c = diff[8];
  assign bus.n = res[7];
  assign bus.h = (~bus.a[3] & bus.b[3]) | (bus.b[3] & res[3]) | (res[3] & ~bus.a[3]);
  assign bus.v = (bus.a[7] & ~bus.b[7] & ~res[7]) | (~bus.a[7] & bus.b[7] & res[7]);
  // A chained compare keeps zero only if the earlier byte was zero too.
  assign bus.z = (res == 8'h00) & (~bus.use_cin | bus.zin);
endmodule
`default_nettype wire

//--- verilog/csb_exec.sv
// Functional notes
// - Register compare updates Z,N,V,C,H only
// - Carry compare subtracts carry, updates Z,N,V,C,H
// - Immediate compare sets flags, stores nothing
// - Register bit clear skips next instruction
// - I/O bit set skips next instruction
// - Flag set branches to PC+k+1
// - Flag clear branches to PC+k+1
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"
module csb_exec #(
  parameter int PC_W = 16  // Program counter width in bits.
)
(
  input  wire logic            mclk_i,         // Core clock, 125 MHz.
  input  wire logic            reset_i,        // Asynchronous reset, high.
  input  wire logic            psel_i,         // APB select.
  input  wire logic            penable_i,      // APB access phase.
  input  wire logic            pwrite_i,       // APB direction.
  input  wire logic [11:0]     paddr_i,        // APB byte address.
  input  wire logic [31:0]     pwdata_i,       // APB write data.
  output logic      [31:0]     prdata_o,       // APB read data.
  output logic                 pready_o,       // APB ready.
  output logic                 pslverr_o,      // APB error on unmapped.
  input  wire logic            instr_valid_i,  // Instruction to execute.
  input  wire logic [15:0]     instr_i,        // Instruction word.
  input  wire logic [7:0]      rd_val_i,       // First register value.
  input  wire logic [7:0]      rr_val_i,       // Second or tested register.
  input  wire logic [7:0]      io_val_i,       // Addressed I/O register.
  input  wire logic            next_two_i,     // Next instruction is two words.
  output logic      [PC_W-1:0] pc_o,           // Program counter.
  output logic      [7:0]      flags_o,        // Status flags register.
  output logic                 done_o,         // Instruction retired pulse.
  output logic                 taken_o         // Skip or branch taken pulse.
);
  // ****************************************************************
  // Declarations.
  // ****************************************************************
  csb_alu_if          alu ();      // Bundle to the subtractor.
  csb_pkg::csb_op_t   op;          // Class of the current word.
  logic               exec;        // Instruction accepted this cycle.
  logic               ctrl_en_r;   // Execution enable from software.
  logic [7:0]         flags_r;     // Status flags register.
  logic [7:0]         flags_nxt;   // Next flags after execution.
  logic [PC_W-1:0]    pc_r;        // Program counter.
  logic [PC_W-1:0]    pc_nxt;      // Next program counter.
  logic [PC_W-1:0]    koff;        // Sign-extended branch offset.
  logic [15:0]        count_r;     // Retired instruction count.
  logic [31:0]        prdata_r;    // Read data captured at setup.
  logic               done_r;      // Retire pulse register.
  logic               taken_r;     // Taken pulse register.
  logic               taken;       // Skip or branch taken now.
  logic               wr_cyc;      // APB write takes effect.
  logic               wr_pc;       // Software write to the counter.
  logic               wr_flags;    // Software write to the flags.
  logic               mapped;      // Address hits a register.
  logic               sel_bit;     // Bit tested by skip or branch.
  logic [7:0]         imm;         // Immediate of the constant compare.

  // ****************************************************************
  // Decode.
  // ****************************************************************
  // Work is gated by the enable so software can freeze the core.
  assign op   = csb_pkg::csb_decode(instr_i);
  assign exec = instr_valid_i & ctrl_en_r;
  assign imm  = {instr_i[11:8], instr_i[3:0]};
  assign koff = {{(PC_W-7){instr_i[9]}}, instr_i[9:3]};

  // The tested bit comes from a register, an I/O port or the flags.
  always_comb
  begin
    case (op)
      csb_pkg::op_skrc, csb_pkg::op_skrs: sel_bit = rr_val_i[instr_i[2:0]];
      csb_pkg::op_skic, csb_pkg::op_skis: sel_bit = io_val_i[instr_i[2:0]];
      csb_pkg::op_brs, csb_pkg::op_brc:   sel_bit = flags_r[instr_i[2:0]];
      default:                            sel_bit = 1'b0;
    endcase
  end

  // Subtractor operands; the constant replaces the second register.
  assign alu.a       = rd_val_i;
  assign alu.b       = (op == csb_pkg::op_cmpi) ? imm : rr_val_i;
  assign alu.cin     = flags_r[`CSB_FLAG_C];
  assign alu.zin     = flags_r[`CSB_FLAG_Z];
  assign alu.use_cin = (op == csb_pkg::op_cmpc);

  csb_alu u_alu (
    .bus (alu.alu)
  );

  // ****************************************************************
  // Next state of flags and program counter.
  // ****************************************************************
  // Only the compares touch the flags; S and the upper bits are kept.
  always_comb
  begin
    flags_nxt = flags_r;
    pc_nxt    = pc_r + PC_W'(1);
    taken     = 1'b0;
    case (op)
      csb_pkg::op_cmp, csb_pkg::op_cmpc, csb_pkg::op_cmpi:
      begin
        flags_nxt[`CSB_FLAG_C] = alu.c;
        flags_nxt[`CSB_FLAG_Z] = alu.z;
        flags_nxt[`CSB_FLAG_N] = alu.n;
        flags_nxt[`CSB_FLAG_V] = alu.v;
        flags_nxt[`CSB_FLAG_H] = alu.h;
      end
      csb_pkg::op_skrc, csb_pkg::op_skic:
        taken = ~sel_bit;
      csb_pkg::op_skrs, csb_pkg::op_skis:
        taken = sel_bit;
      csb_pkg::op_brs:
        taken = sel_bit;
      csb_pkg::op_brc:
        taken = ~sel_bit;
      default:
        taken = 1'b0;
    endcase
    if (taken)
    begin
      if (op == csb_pkg::op_brs || op == csb_pkg::op_brc)
        pc_nxt = pc_r + koff + PC_W'(1);
      else
        pc_nxt = pc_r + (next_two_i ? PC_W'(3) : PC_W'(2));
    end
  end

  // ****************************************************************
  // APB slave.
  // ****************************************************************
  // Zero wait states; read data is latched in the setup cycle.
  assign pready_o  = 1'b1;
  assign mapped    = (paddr_i == `CSB_OFS_CTRL) || (paddr_i == `CSB_OFS_FLAGS) ||
                     (paddr_i == `CSB_OFS_PC) || (paddr_i == `CSB_OFS_COUNT);
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign wr_cyc    = psel_i & penable_i & pwrite_i & mapped;
  assign wr_pc     = wr_cyc & (paddr_i == `CSB_OFS_PC);
  assign wr_flags  = wr_cyc & (paddr_i == `CSB_OFS_FLAGS);
  assign prdata_o  = prdata_r;

  // Read mux; unmapped addresses read as zero.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      prdata_r <= 32'h0000_0000;
    else if (psel_i & ~penable_i)
    begin
      case (paddr_i)
        `CSB_OFS_CTRL:  prdata_r <= {31'h0000_0000, ctrl_en_r};
        `CSB_OFS_FLAGS: prdata_r <= {24'h00_0000, flags_r};
        `CSB_OFS_PC:    prdata_r <= 32'(pc_r);
        `CSB_OFS_COUNT: prdata_r <= {16'h0000, count_r};
        default:        prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Enable bit; clearing it stalls execution without losing state.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl_en_r <= `CSB_CTRL_RST;
    else if (wr_cyc && paddr_i == `CSB_OFS_CTRL)
      ctrl_en_r <= pwdata_i[`CSB_CTRL_EN_BIT];
  end

  // ****************************************************************
  // Architectural state.
  // ****************************************************************
  // A software write wins over a same-cycle instruction, so a debugger
  // can always place the counter and flags where it wants them.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      flags_r <= `CSB_FLAGS_RST;
    else if (wr_flags)
      flags_r <= pwdata_i[7:0];
    else if (exec)
      flags_r <= flags_nxt;
  end

  // Program counter in words.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      pc_r <= PC_W'(`CSB_PC_RST);
    else if (wr_pc)
      pc_r <= pwdata_i[PC_W-1:0];
    else if (exec)
      pc_r <= pc_nxt;
  end

  // Retire counter and pulses; the counter wraps silently.
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_r <= 16'h0000;
      done_r  <= 1'b0;
      taken_r <= 1'b0;
    end
    else
    begin
      count_r <= exec ? count_r + 16'h0001 : count_r;
      done_r  <= exec;
      taken_r <= exec & taken;
    end
  end

  assign pc_o    = pc_r;
  assign flags_o = flags_r;
  assign done_o  = done_r;
  assign taken_o = taken_r;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  logic       cmpc_borrow;  // Independent borrow of the chained compare.
  assign cmpc_borrow = {1'b0, rd_val_i} < ({1'b0, rr_val_i} + {8'h00, flags_r[`CSB_FLAG_C]});

  a_cmp_flags_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_cmp && !wr_flags && !wr_pc |=>
      flags_r[`CSB_FLAG_S] == $past(flags_r[`CSB_FLAG_S]) && pc_r == $past(pc_r) + PC_W'(1)
      && flags_r[`CSB_FLAG_C] == ($past(rd_val_i) < $past(rr_val_i)))
    else $error("register compare changed wrong state");

  a_cmpc_borrow: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_cmpc && !wr_flags |=> flags_r[`CSB_FLAG_C] == $past(cmpc_borrow))
    else $error("carry compare borrow wrong");

  a_cmpi_zero: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_cmpi && !wr_flags |=>
      flags_r[`CSB_FLAG_Z] == ($past(rd_val_i) == $past(imm)))
    else $error("immediate compare zero flag wrong");

  a_skrc_taken: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_skrc && !rr_val_i[instr_i[2:0]] && !next_two_i && !wr_pc
      |=> pc_r == $past(pc_r) + PC_W'(2) && taken_o)
    else $error("register bit clear skip wrong");

  a_skis_flags: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_skis && io_val_i[instr_i[2:0]] && !wr_pc && !wr_flags
      |=> pc_r == $past(pc_r) + ($past(next_two_i) ? PC_W'(3) : PC_W'(2)) && $stable(flags_r))
    else $error("io bit set skip wrong");

  a_brs_target: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_brs && flags_r[instr_i[2:0]] && !wr_pc
      |=> pc_r == $past(pc_r) + $past(koff) + PC_W'(1))
    else $error("flag set branch target wrong");

  a_brc_fall: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && op == csb_pkg::op_brc && flags_r[instr_i[2:0]] && !wr_pc && !wr_flags
      |=> pc_r == $past(pc_r) + PC_W'(1) && !taken_o)
    else $error("flag clear branch not sequential");

  a_skip_two_word: assert property (@(posedge mclk_i) disable iff (reset_i)
    exec && taken && next_two_i && op != csb_pkg::op_brs && op != csb_pkg::op_brc && !wr_pc
      |=> pc_r == $past(pc_r) + PC_W'(3))
    else $error("two word skip not by three");
endmodule
`default_nettype wire

//--- dv/tb_compare_skip_branch_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "csb_defines.svh"
module tb_compare_skip_branch_exec;
  // ****************************************************************
  // Stimulus and observed signals.
  // ****************************************************************
  logic        mclk_i;         // Core clock.
  logic        reset_i;        // Asynchronous reset.
  logic        psel_i;         // Bus select.
  logic        penable_i;      // Bus access phase.
  logic        pwrite_i;       // Bus direction.
  logic [11:0] paddr_i;        // Bus address.
  logic [31:0] pwdata_i;       // Bus write data.
  logic [31:0] prdata_o;       // Bus read data.
  logic        pready_o;       // Bus ready.
  logic        pslverr_o;      // Bus error.
  logic        instr_valid_i;  // Instruction strobe.
  logic [15:0] instr_i;        // Instruction word.
  logic [7:0]  rd_val_i;       // First operand.
  logic [7:0]  rr_val_i;       // Second or tested operand.
  logic [7:0]  io_val_i;       // Tested I/O value.
  logic        next_two_i;     // Following word count.
  logic [15:0] pc_o;           // Program counter.
  logic [7:0]  flags_o;        // Status flags.
  logic        done_o;         // Retire pulse.
  logic        taken_o;        // Skip or branch pulse.
  int          bad_count;      // Mismatches seen.
  int          samples_checked; // Comparisons made.
  // One table row: kind 0 keeps flags, 1 plain, 2 carry, 3 immediate compare.
  typedef struct {
    logic [15:0] ins;
    logic [7:0]  a, b, io;
    logic        two;
    logic [7:0]  fin;
    int          kind, dpc;
    logic        tk;
  } csb_row_t;
  csb_row_t rows[$] = '{
    '{16'h1400, 8'h10, 8'h20, 8'h00, 1'b0, 8'h00, 1, 1, 1'b0},
    '{16'h1400, 8'h80, 8'h01, 8'h00, 1'b0, 8'hD0, 1, 1, 1'b0},
    '{16'h0400, 8'h10, 8'h10, 8'h00, 1'b0, 8'h03, 2, 1, 1'b0},
    '{16'h0400, 8'h10, 8'h0F, 8'h00, 1'b0, 8'h01, 2, 1, 1'b0},
    '{16'h0400, 8'h10, 8'h0F, 8'h00, 1'b0, 8'h03, 2, 1, 1'b0},
    '{16'h350A, 8'h5A, 8'h00, 8'h00, 1'b0, 8'h2F, 3, 1, 1'b0},
    '{16'h3009, 8'h08, 8'h00, 8'h00, 1'b0, 8'h00, 3, 1, 1'b0},
    '{16'hFC03, 8'h00, 8'hF7, 8'h00, 1'b0, 8'h3F, 0, 2, 1'b1},
    '{16'hFC03, 8'h00, 8'h08, 8'hFF, 1'b1, 8'h00, 0, 1, 1'b0},
    '{16'hFC03, 8'h00, 8'hF7, 8'h00, 1'b1, 8'h00, 0, 3, 1'b1},
    '{16'hFE05, 8'h00, 8'h20, 8'h00, 1'b1, 8'h00, 0, 3, 1'b1},
    '{16'hFE05, 8'h00, 8'hDF, 8'h00, 1'b0, 8'h00, 0, 1, 1'b0},
    '{16'h9902, 8'h00, 8'h00, 8'hFB, 1'b0, 8'h00, 0, 2, 1'b1},
    '{16'h9B07, 8'h00, 8'hFF, 8'h80, 1'b0, 8'h3F, 0, 2, 1'b1},
    '{16'h9B07, 8'h00, 8'h00, 8'h7F, 1'b1, 8'h00, 0, 1, 1'b0},
    '{16'h9B07, 8'h00, 8'h00, 8'h80, 1'b1, 8'h00, 0, 3, 1'b1},
    '{16'hF029, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02, 0, 6, 1'b1},
    '{16'hF029, 8'h00, 8'h00, 8'h00, 1'b0, 8'hFD, 0, 1, 1'b0},
    '{16'hF1F8, 8'h00, 8'h00, 8'h00, 1'b0, 8'h01, 0, 64, 1'b1},
    '{16'hF3E8, 8'h00, 8'h00, 8'h00, 1'b0, 8'h01, 0, -2, 1'b1},
    '{16'hF429, 8'h00, 8'h00, 8'h00, 1'b0, 8'hFD, 0, 6, 1'b1},
    '{16'hF429, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02, 0, 1, 1'b0},
    '{16'hF600, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 0, -63, 1'b1},
    '{16'h0000, 8'h00, 8'h00, 8'h00, 1'b0, 8'h5A, 0, 1, 1'b0}
  };

  csb_exec #(.PC_W(16)) csb_exec_i (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .rd_val_i(rd_val_i),
    .rr_val_i(rr_val_i), .io_val_i(io_val_i), .next_two_i(next_two_i), .pc_o(pc_o),
    .flags_o(flags_o), .done_o(done_o), .taken_o(taken_o));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Free-running core clock, 8 ns period.
  always #4 mclk_i = ~mclk_i;

  // Expected flags of a compare; bits other than C, Z, N, V, H keep their value.
  function automatic logic [7:0] exp_flags(int kind, logic [15:0] ins, logic [7:0] a, b, fin);
    logic [7:0] f, bb, r;
    logic       ci;
    f  = fin;
    bb = (kind == 3) ? {ins[11:8], ins[3:0]} : b;
    ci = (kind == 2) ? fin[0] : 1'b0;
    if (kind != 0)
    begin
      r    = a - bb - {7'h00, ci};
      f[0] = ({1'b0, a} < {1'b0, bb} + {8'h00, ci});
      // The carry compare only keeps Z set, so multi-byte equality chains.
      f[1] = (r == 8'h00) && (kind != 2 || fin[1]);
      f[2] = r[7];
      f[3] = (a[7] & ~bb[7] & ~r[7]) | (~a[7] & bb[7] & r[7]);
      f[5] = ({1'b0, a[3:0]} < {1'b0, bb[3:0]} + {4'h0, ci});
    end
    return f;
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex)
    begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  // One bus transfer; it waits for ready rather than assuming zero wait states.
  // Only the watchdog ends a wait that never sees ready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Presents one instruction for exactly one sampling edge.
  task automatic issue(input logic [15:0] ins, input logic [7:0] a, b, io, input logic two);
    instr_valid_i <= 1'b1;
    instr_i       <= ins;
    rd_val_i      <= a;
    rr_val_i      <= b;
    io_val_i      <= io;
    next_two_i    <= two;
    @(posedge mclk_i);
  endtask

  // Single exit point for both normal end and watchdog.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the whole run needs well under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    print_verdict();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [7:0]  f;
    {mclk_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {instr_valid_i, instr_i, rd_val_i, rr_val_i, io_val_i, next_two_i} = '0;
    bad_count = 0;
    samples_checked = 0;
    reset_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    // Table rows: preload flags and counter, run one instruction, compare.
    foreach (rows[i])
    begin
      apb(1'b1, `CSB_OFS_FLAGS, {24'h0, rows[i].fin}, q, e);
      apb(1'b1, `CSB_OFS_PC, 32'h100, q, e);
      issue(rows[i].ins, rows[i].a, rows[i].b, rows[i].io, rows[i].two);
      instr_valid_i <= 1'b0;
      #1;
      chk("done", 32'h1, {31'h0, done_o});
      chk("taken", {31'h0, rows[i].tk}, {31'h0, taken_o});
      chk("pc", 32'(16'(32'h100 + rows[i].dpc)), {16'h0, pc_o});
      f = exp_flags(rows[i].kind, rows[i].ins, rows[i].a, rows[i].b, rows[i].fin);
      chk("flags", {24'h0, f}, {24'h0, flags_o});
    end
    // Back to back: the branch must see the chained zero of the previous compares.
    apb(1'b1, `CSB_OFS_FLAGS, 32'h0, q, e);
    apb(1'b1, `CSB_OFS_PC, 32'h100, q, e);
    issue(16'h1400, 8'h34, 8'h34, 8'h00, 1'b0);
    issue(16'h0400, 8'h12, 8'h12, 8'h00, 1'b0);
    issue(16'hF029, 8'h00, 8'h00, 8'h00, 1'b0);
    instr_valid_i <= 1'b0;
    #1;
    f = exp_flags(2, 16'h0400, 8'h12, 8'h12, exp_flags(1, 16'h1400, 8'h34, 8'h34, 8'h00));
    chk("chain flags", {24'h0, f}, {24'h0, flags_o});
    chk("chain pc", 32'h108, {16'h0, pc_o});
    // Disabled core ignores instructions.
    apb(1'b1, `CSB_OFS_CTRL, 32'h0, q, e);
    issue(16'h0000, 8'h00, 8'h00, 8'h00, 1'b0);
    instr_valid_i <= 1'b0;
    #1;
    chk("idle done", 32'h0, {31'h0, done_o});
    chk("idle pc", 32'h108, {16'h0, pc_o});
    // Unmapped address answers with an error and zero data.
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk("unmapped data", 32'h0, q);
    chk("unmapped err", 32'h1, {31'h0, e});
    // Counter and program counter read back; 24 table rows and 3 chained retire.
    apb(1'b0, `CSB_OFS_PC, 32'h0, q, e);
    chk("read pc", 32'h108, q);
    chk("mapped err", 32'h0, {31'h0, e});
    chk("ready", 32'h1, {31'h0, pready_o});
    apb(1'b0, `CSB_OFS_COUNT, 32'h0, q, e);
    chk("read count", 32'h1B, q);
    // Second reset in mid-run restores the reset values of PC, flags and enable.
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    chk("reset pc", 32'h0, {16'h0, pc_o});
    chk("reset flags", 32'h0, {24'h0, flags_o});
    apb(1'b0, `CSB_OFS_CTRL, 32'h0, q, e);
    chk("reset ctrl", 32'h1, q);
    apb(1'b0, `CSB_OFS_FLAGS, 32'h0, q, e);
    chk("reset flags reg", 32'h0, q);
    print_verdict();
  end
endmodule
`default_nettype wire
